/* core/afbp_host.v */
/*
 * Host controller for an 8K x 8 asynchronous bytewide memory port.
 * A user request with address, data and direction becomes one chip
 * enable controlled access with a precharge afterwards.
 * Assumes the memory pins are wired directly, the data bus resolved
 * by the memory model from the enable, and a 125 MHz clock.
 */
`timescale 1ns/10ps
`include "afbp_defs.vh"

module afbp_host #(
	parameter AW     = `AFBP_ADDR_W,
	parameter DW     = `AFBP_DATA_W,
	parameter PU_CYC = `AFBP_CYC_PU
) (
	input  wire          SYS_CLK_IN,
	input  wire          RST_IN,
	input  wire          REQ_VALID_IN,
	input  wire          REQ_WRITE_IN,
	input  wire [AW-1:0] REQ_ADDR_IN,
	input  wire [DW-1:0] REQ_WDATA_IN,
	output wire          REQ_READY_OUT,
	output reg  [DW-1:0] RD_DATA_OUT,
	output reg           RD_VALID_OUT,
	output reg           MEM_CE_N_OUT,
	output reg           MEM_WE_N_OUT,
	output reg           MEM_OE_N_OUT,
	output reg  [AW-1:0] MEM_ADDR_OUT,
	output reg  [DW-1:0] MEM_DQ_OUT,
	output reg           MEM_DQ_OE_N_OUT,
	input  wire [DW-1:0] MEM_DQ_IN
);

	localparam CW = `AFBP_CNT_W;

	// Power-up wait as a timer load, cut on purpose to the counter width.
	localparam [CW-1:0] PU_LOAD = PU_CYC[CW-1:0];

	// One-hot states.
	localparam S_PWRUP = 6'h01;
	localparam S_IDLE  = 6'h02;
	localparam S_SETUP = 6'h04;
	localparam S_ACT   = 6'h08;
	localparam S_HOLD  = 6'h10;
	localparam S_PRE   = 6'h20;

	reg  [5:0]    state_r;
	reg  [5:0]    state_nxt;
	reg           write_r;
	reg           load_r;
	reg  [CW-1:0] load_val_r;
	reg  [DW-1:0] dq_s1_r;
	reg  [DW-1:0] dq_s2_r;
	wire          done;
	wire          enter;
	wire          read_end;

	// Turns a cycle count into the timer load value.
	function [CW-1:0] cyc;
		input integer n;
		begin
			cyc = n[CW-1:0];
		end
	endfunction

	// True on the edge that begins phase s, so that each phase acts once.
	function entering;
		input [5:0] nxt;
		input [5:0] cur;
		input [5:0] s;
		begin
			entering = (nxt == s) && (nxt != cur);
		end
	endfunction

	afbp_timer #(
		.W (CW)
	) u_timer (
		.clk_in   (SYS_CLK_IN),
		.rst_in   (RST_IN),
		.load_in  (load_r),
		.value_in (load_val_r),
		.done_out (done)
	);

	// Read data from the pins passes two flip-flops before use.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			dq_s1_r <= {DW{1'b0}};
			dq_s2_r <= {DW{1'b0}};
		end else begin
			dq_s1_r <= MEM_DQ_IN;
			dq_s2_r <= dq_s1_r;
		end
	end

	// Ready only in idle, straight from the state register.
	assign REQ_READY_OUT = state_r[1];

	// A phase begins on the edge where the next state differs.
	// Holding a phase never repeats its entry actions, so a request
	// that changes while the host is busy cannot leak into the pins.
	assign enter = (state_nxt != state_r);

	// A read ends, and its byte is handed over, as enable rises.
	assign read_end = entering(state_nxt, state_r, S_HOLD) && !write_r;

	// Next state follows the timer at the end of each phase; idle waits for a valid request.
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_PWRUP: if (done) state_nxt = S_IDLE;
			S_IDLE:  if (REQ_VALID_IN) state_nxt = S_SETUP;
			S_SETUP: if (done) state_nxt = S_ACT;
			S_ACT:   if (done) state_nxt = S_HOLD;
			S_HOLD:  if (done) state_nxt = S_PRE;
			S_PRE:   if (done) state_nxt = S_IDLE;
			default: state_nxt = S_PWRUP;
		endcase
	end

	// State register; reset lands in the power-up wait.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_r <= S_PWRUP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timer length for each phase, loaded once on the entry edge.
	// Reset preloads the power-up wait so that it starts at once
	// and the load pulse lasts a single cycle.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			load_r     <= 1'b1;
			load_val_r <= PU_LOAD;
		end else begin
			load_r <= enter;
			if (enter) begin
				case (state_nxt)
					S_PWRUP: load_val_r <= PU_LOAD;
					S_SETUP: load_val_r <= cyc(1);
					// Covers enable access, gate access and data setup.
					S_ACT: load_val_r <= cyc(`AFBP_CYC_CA);
					S_HOLD: load_val_r <= cyc(`AFBP_CYC_AH);
					S_PRE: load_val_r <= cyc(`AFBP_CYC_PC);
					default: load_val_r <= load_val_r;
				endcase
			end
		end
	end

	// Chip, write and output enables change only on phase entry.
	// A write is always enable controlled: the strobe is low before
	// enable falls and rises on the same edge as enable.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			MEM_CE_N_OUT <= 1'b1;
			MEM_WE_N_OUT <= 1'b1;
			MEM_OE_N_OUT <= 1'b1;
		end else if (enter) begin
			case (state_nxt)
				S_SETUP: begin
					// Strobe settles while enable is still high.
					MEM_WE_N_OUT <= !REQ_WRITE_IN;
				end
				S_ACT: begin
					MEM_CE_N_OUT <= 1'b0;
					MEM_OE_N_OUT <= write_r;
				end
				S_HOLD: begin
					// Enable and strobe rise together, ending the access.
					MEM_CE_N_OUT <= 1'b1;
					MEM_WE_N_OUT <= 1'b1;
					MEM_OE_N_OUT <= 1'b1;
				end
				default: begin
					// Idle, precharge and power-up keep every enable high.
					MEM_CE_N_OUT <= 1'b1;
					MEM_WE_N_OUT <= 1'b1;
					MEM_OE_N_OUT <= 1'b1;
				end
			endcase
		end
	end

	// Address, data and direction latch on the edge that takes the
	// request, and stay put until the next request is taken, well
	// past the address hold after enable falls.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			write_r         <= 1'b0;
			MEM_ADDR_OUT    <= {AW{1'b0}};
			MEM_DQ_OUT      <= {DW{1'b0}};
			MEM_DQ_OE_N_OUT <= 1'b1;
		end else if (entering(state_nxt, state_r, S_SETUP)) begin
			write_r         <= REQ_WRITE_IN;
			MEM_ADDR_OUT    <= REQ_ADDR_IN;
			MEM_DQ_OUT      <= REQ_WDATA_IN;
			MEM_DQ_OE_N_OUT <= !REQ_WRITE_IN;
		end else if (entering(state_nxt, state_r, S_PRE)) begin
			// Bus released only after the write edge, never before.
			MEM_DQ_OE_N_OUT <= 1'b1;
		end
	end

	// One result pulse per read; the byte stands until the next read.
	// The extra active cycle leaves the byte time to pass both
	// synchroniser stages before it is taken here.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RD_DATA_OUT  <= {DW{1'b0}};
			RD_VALID_OUT <= 1'b0;
		end else begin
			RD_VALID_OUT <= read_end;
			if (read_end) begin
				RD_DATA_OUT <= dq_s2_r;
			end
		end
	end

endmodule

/* pkg/afbp_defs.vh */
/*
 * Constants for the host controller of an asynchronous bytewide
 * nonvolatile memory port. Times are in nanoseconds unless named
 * otherwise; cycle counts derive from the 125 MHz system clock.
 * Assumes inclusion by bare name from each design file.
 */
`ifndef AFBP_DEFS_VH
`define AFBP_DEFS_VH

`define AFBP_CLK_PERIOD_NS  8
`define AFBP_ADDR_W         13
`define AFBP_DATA_W         8

// Least times from the low supply column, which also covers high supply.
`define AFBP_T_CA_NS        80
`define AFBP_T_PC_NS        65
`define AFBP_T_AH_NS        15
`define AFBP_T_WP_NS        50
`define AFBP_T_DS_NS        40
`define AFBP_T_CE_ACC_NS    80
`define AFBP_T_OE_ACC_NS    15
`define AFBP_T_HZ_NS        15
`define AFBP_T_PU_MS        10

// Least times round up to whole cycles; the enable access time alone gets one extra cycle to cover sampling.
`define AFBP_CYC_UP(ns) \
	(((ns) + `AFBP_CLK_PERIOD_NS - 1) / `AFBP_CLK_PERIOD_NS)
`define AFBP_CYC_CA     (`AFBP_CYC_UP(`AFBP_T_CA_NS) + 1)
`define AFBP_CYC_PC     `AFBP_CYC_UP(`AFBP_T_PC_NS)
`define AFBP_CYC_AH     `AFBP_CYC_UP(`AFBP_T_AH_NS)
`define AFBP_CYC_WP     `AFBP_CYC_UP(`AFBP_T_WP_NS)
`define AFBP_CYC_DS     `AFBP_CYC_UP(`AFBP_T_DS_NS)
`define AFBP_CYC_HZ     `AFBP_CYC_UP(`AFBP_T_HZ_NS)
`define AFBP_CYC_PU     ((`AFBP_T_PU_MS * 1000000) / `AFBP_CLK_PERIOD_NS)

`define AFBP_CNT_W      21

`endif

/* core/afbp_timer.v */
/*
 * Down counter that paces each phase of the host controller.
 * Assumes a single clock and an asynchronous active high reset.
 */
`timescale 1ns/10ps
`include "afbp_defs.vh"

module afbp_timer #(
	parameter W = `AFBP_CNT_W
) (
	input  wire         clk_in,
	input  wire         rst_in,
	input  wire         load_in,
	input  wire [W-1:0] value_in,
	output wire         done_out
);

	reg [W-1:0] cnt_r;

	// Loads the phase length, then counts down to zero and holds.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= {W{1'b0}};
		end else if (load_in) begin
			cnt_r <= value_in;
		end else if (cnt_r != {W{1'b0}}) begin
			cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end

	// The phase is over once the count reaches zero.
	assign done_out = (cnt_r == {W{1'b0}}) && !load_in;

endmodule

/* bench/afbp_checker.sv */
/* Strobe timing checker for the host port.
   Assumes a bind onto the host controller. */
`timescale 1ns/10ps
module afbp_checker #(parameter PU_CYC = 20) (
	input	wire		SYS_CLK_IN,
	input	wire		RST_IN,
	input	wire		MEM_CE_N_OUT,
	input	wire		MEM_WE_N_OUT,
	input	wire		MEM_OE_N_OUT,
	input	wire	[12:0]	MEM_ADDR_OUT,
	input	wire	[7:0]	MEM_DQ_OUT,
	input	wire		MEM_DQ_OE_N_OUT
);
	reg	[31:0]	up_r;
	// Counts clocks after reset up to the power-up wait.
	always @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			up_r <= 32'h0;
		else if (up_r < PU_CYC)
			up_r <= up_r + 32'h1;
	end
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence ce_low10;
		!MEM_CE_N_OUT[*8] ##1 !MEM_CE_N_OUT[*2];
	endsequence
	sequence we_low10;
		!MEM_WE_N_OUT[*8] ##1 !MEM_WE_N_OUT[*2];
	endsequence
	ce_active_a: assert property ($fell(MEM_CE_N_OUT) |-> ce_low10)
		else $error("enable low too short");
	precharge_a: assert property ($rose(MEM_CE_N_OUT) |->
		MEM_CE_N_OUT[*8] ##1 MEM_CE_N_OUT) else $error("precharge short");
	addr_hold_a: assert property ($fell(MEM_CE_N_OUT) |=>
		$stable(MEM_ADDR_OUT)[*2]) else $error("address moved");
	we_after_ce_a: assert property ($fell(MEM_CE_N_OUT) &&
		!MEM_WE_N_OUT |-> we_low10) else $error("strobe rose early");
	we_pulse_a: assert property ($fell(MEM_WE_N_OUT) |->
		!MEM_WE_N_OUT[*7]) else $error("strobe pulse short");
	we_setup_a: assert property ($fell(MEM_WE_N_OUT) |-> MEM_CE_N_OUT)
		else $error("strobe fell late");
	we_hold_a: assert property (!MEM_CE_N_OUT && !MEM_WE_N_OUT |=>
		MEM_CE_N_OUT || !MEM_WE_N_OUT) else $error("strobe left early");
	data_setup_a: assert property ($rose(MEM_WE_N_OUT) |->
		$past(MEM_DQ_OUT) == $past(MEM_DQ_OUT, 5) &&
		!$past(MEM_DQ_OE_N_OUT, 5)) else $error("data setup short");
	power_up_a: assert property (!MEM_CE_N_OUT |-> up_r == PU_CYC)
		else $error("access before wait");
	oe_read_only_a: assert property (!MEM_OE_N_OUT |->
		!MEM_CE_N_OUT && MEM_WE_N_OUT) else $error("gate low outside read");
	dq_release_a: assert property ($rose(MEM_DQ_OE_N_OUT) |->
		MEM_CE_N_OUT && MEM_WE_N_OUT) else $error("bus released early");
endmodule

/* bench/afbp_mem_model.sv */
/* Behavioural model of the bytewide memory.
   Assumes the bench resolves nothing; bus_out is the pin level. */
`timescale 1ns/10ps
module afbp_mem_model (
	input	wire		ce_n_in,
	input	wire		we_n_in,
	input	wire		oe_n_in,
	input	wire	[12:0]	addr_in,
	input	wire	[7:0]	host_dq_in,
	input	wire		host_oe_n_in,
	output	wire	[7:0]	bus_out
);
	reg	[7:0]	mem_r [0:8191];
	reg	[12:0]	lat_r;
	reg	[7:0]	junk_r = 8'h3C;
	wire		wr = !ce_n_in && !we_n_in;
	wire		rd = !ce_n_in && we_n_in && !oe_n_in;
	wire	#80	acc = !ce_n_in;
	wire	#15	drv = rd;
	// Latches the address, and stores the bus level when a write ends.
	always @(negedge ce_n_in) lat_r = addr_in;
	always @(negedge wr) mem_r[lat_r] = bus_out;
	// A bus nobody drives shows a changing pattern.
	always #8 junk_r = junk_r + 8'h3B;
	assign bus_out = !host_oe_n_in ? host_dq_in :
		(drv && acc) ? mem_r[lat_r] : junk_r;
endmodule

/* bench/testbench.sv */
/* Self-checking bench for the host controller.
   Assumes the memory model and the bound checker. */
`timescale 1ns/10ps
module testbench;
	reg		clk = 1'b0;
	reg		rst = 1'b1;
	reg		valid = 1'b0;
	reg		wr = 1'b0;
	reg	[12:0]	addr = 13'h0;
	reg	[12:0]	a;
	reg	[7:0]	wdata = 8'h0;
	reg	[31:0]	lfsr = 32'hC303B6A4;
	reg	[7:0]	shadow [0:8191];
	reg	[7:0]	exp_q [$];
	integer		errors = 0;
	integer		n_checks = 0;
	integer		i;
	wire		ready, rd_valid, ce_n, we_n, oe_n, dq_oe_n;
	wire	[12:0]	mem_addr;
	wire	[7:0]	rd_data, dq_out, dq_bus;
	afbp_host #(.PU_CYC(20)) dut (.SYS_CLK_IN(clk), .RST_IN(rst),
		.REQ_VALID_IN(valid), .REQ_WRITE_IN(wr), .REQ_ADDR_IN(addr),
		.REQ_WDATA_IN(wdata), .REQ_READY_OUT(ready), .RD_DATA_OUT(rd_data),
		.RD_VALID_OUT(rd_valid), .MEM_CE_N_OUT(ce_n), .MEM_WE_N_OUT(we_n),
		.MEM_OE_N_OUT(oe_n), .MEM_ADDR_OUT(mem_addr), .MEM_DQ_OUT(dq_out),
		.MEM_DQ_OE_N_OUT(dq_oe_n), .MEM_DQ_IN(dq_bus));
	afbp_mem_model mem (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
		.addr_in(mem_addr), .host_dq_in(dq_out), .host_oe_n_in(dq_oe_n),
		.bus_out(dq_bus));
	always #4 clk = ~clk;
	function [31:0] step(input [31:0] s);
		step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task end_of_test;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Holds one request until it is taken, then notes the expected byte.
	task op(input w, input [12:0] ad, input [7:0] d);
		begin
			@(posedge clk);
			valid <= 1'b1;
			wr <= w;
			addr <= ad;
			wdata <= d;
			@(negedge clk);
			while (ready !== 1'b1)
				@(negedge clk);
			@(posedge clk);
			valid <= 1'b0;
			if (w)
				shadow[ad] = d;
			else
				exp_q.push_back(shadow[ad]);
		end
	endtask
	// Compares each read result with the oldest note.
	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			n_checks = n_checks + 1;
			if (rd_data !== exp_q[0]) begin
				errors = errors + 1;
				$display("Error rd_data exp %h seen %h", exp_q[0], rd_data);
			end
			void'(exp_q.pop_front());
		end
	end
	// Writes then reads back, edge addresses first, request raised one clock after reset ends and held through the power-up wait.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 24; i = i + 1) begin
			lfsr = step(lfsr);
			a = (i < 2) ? {13{i[0]}} : lfsr[12:0];
			op(1'b1, a, lfsr[20:13]);
			op(1'b0, a, 8'h00);
		end
		repeat (40) @(posedge clk);
		if (exp_q.size() != 0) begin
			errors = errors + 1;
			$display("Error reads expected 0 seen %0d", exp_q.size());
		end
		end_of_test;
	end
	// Cuts a hang short.
	initial begin
		#100000;
		errors = errors + 1;
		end_of_test;
	end
endmodule
bind afbp_host afbp_checker #(.PU_CYC(PU_CYC)) chk (.SYS_CLK_IN, .RST_IN,
	.MEM_CE_N_OUT, .MEM_WE_N_OUT, .MEM_ADDR_OUT, .MEM_DQ_OUT,
	.MEM_DQ_OE_N_OUT, .MEM_OE_N_OUT);
